//--- hw/stream_src_ctrl.sv
/*
 * Streaming source controller: software stages one beat at a time
 * through a plain register port and the block presents it on a
 * point-to-point stream toward a sink, honouring backpressure.
 * Assumes the sink shares core_clk and reset_n and drives src_ready
 * from logic on the same clock.
 */
// Our own choices: the address map and the plain strobed port.
`timescale 1ns/100ps
module stream_src_ctrl #(
    parameter int beat_symbol_count    = stream_src_pkg::DEF_SYMBOLS,
    parameter int symbol_bit_width     = stream_src_pkg::DEF_SYMBOL_BITS,
    parameter int channel_width        = 8,
    parameter int error_width          = 8,
    parameter int channel_number_limit = stream_src_pkg::DEF_CHAN_LIMIT,
    parameter int backpressure_delay   = stream_src_pkg::DEF_READY_DELAY,
    parameter bit lead_symbol_msb_order = stream_src_pkg::DEF_MSB_ORDER,
    parameter int data_width  = beat_symbol_count * symbol_bit_width,
    parameter int empty_width = (beat_symbol_count > 1) ? $clog2(beat_symbol_count) : 1
) (
    input  wire logic                     core_clk,  // 250 MHz clock
    input  wire logic                     reset_n,   // Sync reset, low
    input  wire logic [3:0]               addr,      // Register byte offset
    input  wire logic [31:0]              wr_data,   // Write data
    input  wire logic                     wr_strobe, // Write, one cycle
    input  wire logic                     rd_strobe, // Read, one cycle
    output logic      [31:0]              rd_data,   // Read data, next cycle
    input  wire logic                     src_ready, // Sink backpressure release
    output logic                          src_valid, // Beat qualifier
    output logic      [data_width-1:0]    src_data,  // Beat payload
    output logic      [channel_width-1:0] src_channel, // Channel number
    output logic      [error_width-1:0]   src_error, // Error mask
    output logic                          src_sop,   // Packet start
    output logic                          src_eop,   // Packet end
    output logic      [empty_width-1:0]   src_empty  // Unused symbols
);
    import stream_src_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [31:0]              ctrl_ff,  nxt_ctrl;    // Staged control
    logic [31:0]              data_ff,  nxt_data;    // Staged payload
    logic                     pend_ff,  nxt_pend;    // Beat queued
    logic                     fault_ff, nxt_fault;   // Channel fault
    logic [15:0]              count_ff, nxt_count;   // Beats sent
    logic [LAT_MAX-1:0]       dly_ff,   nxt_dly;     // Ready history
    logic [31:0]              rd_ff,    nxt_rd;      // Read answer
    logic                     val_ff,   nxt_val;     // Qualifier
    logic [data_width-1:0]    dat_ff,   nxt_dat;     // Payload out
    logic [channel_width-1:0] ch_ff,    nxt_ch;      // Channel out
    logic [error_width-1:0]   err_ff,   nxt_err;     // Error out
    logic                     sop_ff,   nxt_sop;     // Start out
    logic                     eop_ff,   nxt_eop;     // End out
    logic [empty_width-1:0]   emp_ff,   nxt_emp;     // Empty out

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    logic [LAT_MAX:0]      hist;     // Ready now and earlier
    logic                  fire;     // Transfer this cycle
    logic                  next_rc;  // Next cycle is a ready cycle
    logic                  load;     // Move staged beat out
    logic                  go;       // Software queues a beat
    logic                  chan_bad; // Requested channel over limit
    logic [data_width-1:0] wide;     // Staged payload, beat wide

    // Software writes symbol 0 in the high bits; swap when the
    // stream wants symbol 0 in the low bits. Only the low 32 bits
    // of a wide beat are reachable from the register port.
    function automatic logic [data_width-1:0] order_syms(
        input logic [data_width-1:0] in
    );
        logic [data_width-1:0] out;
        out = in;
        if (!lead_symbol_msb_order) begin
            for (int i = 0; i < beat_symbol_count; i++) begin
                out[(beat_symbol_count-1-i)*symbol_bit_width +: symbol_bit_width] =
                    in[i*symbol_bit_width +: symbol_bit_width];
            end
        end
        return out;
    endfunction

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        hist = {dly_ff, src_ready};
        // Ready on cycle n marks cycle n plus latency ready
        // Index guarded so a zero latency never selects below bit 0
        next_rc = (backpressure_delay == 0) ? 1'b0 :
                  hist[(backpressure_delay == 0) ? 0 : backpressure_delay-1];
        // Zero latency needs both high; otherwise valid means ready
        fire = val_ff && ((backpressure_delay != 0) || src_ready);
        go = wr_strobe && (addr == ADDR_CTRL) && wr_data[CTRL_GO];
        chan_bad = int'(wr_data[CTRL_CHAN_LSB +: 8]) > channel_number_limit;
        wide = '0;
        for (int i = 0; i < 32 && i < data_width; i++) begin
            wide[i] = data_ff[i];
        end
        // Zero latency: refill when empty or draining; else only ready cycles
        if (backpressure_delay == 0) begin
            load = pend_ff && (!val_ff || fire);
        end else begin
            load = pend_ff && next_rc;
        end
        nxt_dly = hist[LAT_MAX-1:0];
        nxt_ctrl = ctrl_ff;
        nxt_data = data_ff;
        nxt_fault = fault_ff;
        nxt_count = fire ? count_ff + 16'h0001 : count_ff;
        // Loaded beat leaves the queue; a new go in the same cycle wins
        nxt_pend = pend_ff && !load;
        if (wr_strobe) begin
            if (addr == ADDR_CTRL) begin
                if (go && chan_bad) begin
                    nxt_fault = 1'b1;  // Refused, stays queued-free
                end else begin
                    nxt_ctrl = wr_data;
                    nxt_pend = go || nxt_pend;
                end
            end else if (addr == ADDR_DATA) begin
                nxt_data = wr_data;
            end else if (addr == ADDR_STATUS) begin
                // Writing one clears the fault
                nxt_fault = fault_ff && !wr_data[STAT_FAULT];
            end
        end
        // Payload, channel and error hold until replaced; markers and empty clear when the qualifier drops
        nxt_dat = dat_ff;
        nxt_ch = ch_ff;
        nxt_err = err_ff;
        nxt_sop = sop_ff;
        nxt_eop = eop_ff;
        nxt_emp = emp_ff;
        if (load) begin
            nxt_val = 1'b1;
            nxt_dat = order_syms(wide);
            nxt_ch = channel_width'(ctrl_ff[CTRL_CHAN_LSB +: 8]);
            nxt_err = error_width'(ctrl_ff[CTRL_ERR_LSB +: 8]);
            nxt_sop = ctrl_ff[CTRL_SOP];
            nxt_eop = ctrl_ff[CTRL_EOP];
            // Count only on end beats of multi-symbol streams
            nxt_emp = (beat_symbol_count > 1 && ctrl_ff[CTRL_EOP]) ?
                      empty_width'(ctrl_ff[CTRL_EMPTY_LSB +: 8]) : '0;
        end else if (backpressure_delay == 0) begin
            nxt_val = val_ff && !fire;  // Hold until taken
        end else begin
            nxt_val = 1'b0;  // Never valid off a ready cycle
        end
        // Markers never stand without the qualifier
        if (!nxt_val) begin
            nxt_sop = 1'b0;
            nxt_eop = 1'b0;
            nxt_emp = '0;  // Unused count idles at zero too
        end
        // Register read port, answer next cycle
        nxt_rd = RST_WORD;
        if (rd_strobe) begin
            if (addr == ADDR_CTRL) begin
                nxt_rd = ctrl_ff;
            end else if (addr == ADDR_DATA) begin
                nxt_rd = data_ff;
            end else if (addr == ADDR_STATUS) begin
                nxt_rd = {29'h0, fault_ff, val_ff, pend_ff};
            end else if (addr == ADDR_COUNT) begin
                nxt_rd = {16'h0, count_ff};
            end else begin
                nxt_rd = RST_WORD;  // Unmapped reads zero
            end
        end
    end

    // ------------------------------------------------------------
    // Registers, rising edge only
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            ctrl_ff <= RST_WORD;
            data_ff <= RST_WORD;
            pend_ff <= RST_BIT;
            fault_ff <= RST_BIT;
            count_ff <= '0;
            dly_ff <= '0;
            rd_ff <= RST_WORD;
            val_ff <= RST_BIT;
            dat_ff <= '0;
            ch_ff <= '0;
            err_ff <= '0;
            sop_ff <= RST_BIT;
            eop_ff <= RST_BIT;
            emp_ff <= '0;
        end else begin
            ctrl_ff <= nxt_ctrl;
            data_ff <= nxt_data;
            pend_ff <= nxt_pend;
            fault_ff <= nxt_fault;
            count_ff <= nxt_count;
            dly_ff <= nxt_dly;
            rd_ff <= nxt_rd;
            val_ff <= nxt_val;
            dat_ff <= nxt_dat;
            ch_ff <= nxt_ch;
            err_ff <= nxt_err;
            sop_ff <= nxt_sop;
            eop_ff <= nxt_eop;
            emp_ff <= nxt_emp;
        end
    end

    // ------------------------------------------------------------
    // Outputs straight from flip-flops
    // ------------------------------------------------------------
    assign rd_data = rd_ff;
    assign src_valid = val_ff;
    assign src_data = dat_ff;
    assign src_channel = ch_ff;
    assign src_error = err_ff;
    assign src_sop = sop_ff;
    assign src_eop = eop_ff;
    assign src_empty = emp_ff;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    property p_reset_quiet;
        $rose(reset_n) |-> !src_valid && !src_sop && !src_eop;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("stream busy after reset");

    property p_markers_qualified;
        (src_sop || src_eop) |-> src_valid;
    endproperty
    a_markers_qualified: assert property (p_markers_qualified) else $error("marker w/o valid");

    property p_hold_when_stalled;
        (backpressure_delay == 0) && src_valid && !src_ready |=>
            src_valid && $stable(src_data) && $stable(src_eop);
    endproperty
    a_hold_when_stalled: assert property (p_hold_when_stalled) else $error("beat dropped");

    // Ready-cycle prediction one cycle late, for the latency check
    logic rc_pred_ff;  // Previous cycle predicted a ready cycle
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            rc_pred_ff <= RST_BIT;
        end else begin
            rc_pred_ff <= next_rc;
        end
    end

    property p_valid_on_ready_cycle;
        (backpressure_delay != 0) && src_valid |-> rc_pred_ff;
    endproperty
    a_valid_on_ready_cycle: assert property (p_valid_on_ready_cycle) else $error("valid off ready");

    property p_empty_single;
        (beat_symbol_count == 1) |-> src_empty == '0;
    endproperty
    a_empty_single: assert property (p_empty_single) else $error("empty on single symbol");

    property p_empty_needs_end;
        src_valid && !src_eop |-> src_empty == '0;
    endproperty
    a_empty_needs_end: assert property (p_empty_needs_end) else $error("empty w/o end");

    property p_channel_limit;
        src_valid |-> int'(src_channel) <= channel_number_limit;
    endproperty
    a_channel_limit: assert property (p_channel_limit) else $error("channel over limit");

    property p_count_step;
        src_valid && (src_ready || backpressure_delay != 0) |=>
            count_ff == $past(count_ff) + 16'h0001;
    endproperty
    a_count_step: assert property (p_count_step) else $error("count missed beat");

    property p_go_presents;
        (backpressure_delay == 0) && go && !chan_bad && !pend_ff && !src_valid
            |=> ##1 src_valid;
    endproperty
    a_go_presents: assert property (p_go_presents) else $error("go not presented");

    c_sop_taken: cover property (src_valid && src_sop && fire);
    c_eop_taken: cover property (src_valid && src_eop && fire);
    c_stalled: cover property (src_valid && !src_ready ##1 src_valid && src_ready);
    c_fault: cover property ($rose(fault_ff));
endmodule

//--- inc/stream_src_pkg.sv
/*
 * Constants for the streaming source controller: register offsets,
 * field positions, reset values and parameter defaults.
 * Assumes a plain software port with byte offsets in 32-bit words.
 */
package stream_src_pkg;
    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [3:0] ADDR_CTRL   = 4'h0;  // Beat control, go
    localparam logic [3:0] ADDR_DATA   = 4'h4;  // Beat payload
    localparam logic [3:0] ADDR_STATUS = 4'h8;  // Status, fault clear
    localparam logic [3:0] ADDR_COUNT  = 4'hc;  // Beats sent
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CTRL_GO        = 0;   // Queue staged beat
    localparam int CTRL_SOP       = 1;   // Packet start marker
    localparam int CTRL_EOP       = 2;   // Packet end marker
    localparam int CTRL_EMPTY_LSB = 8;   // Unused symbols, 8 bits
    localparam int CTRL_CHAN_LSB  = 16;  // Channel, 8 bits
    localparam int CTRL_ERR_LSB   = 24;  // Error mask, 8 bits
    localparam int STAT_PEND      = 0;   // Beat waiting
    localparam int STAT_VALID     = 1;   // Qualifier now high
    localparam int STAT_FAULT     = 2;   // Channel over limit
    // ------------------------------------------------------------
    // Reset values and defaults
    // ------------------------------------------------------------
    localparam logic [31:0] RST_WORD = 32'h0;  // Registers after reset
    localparam logic        RST_BIT  = 1'b0;   // Flags after reset
    localparam int DEF_SYMBOLS     = 1;        // Symbols per beat
    localparam int DEF_SYMBOL_BITS = 8;        // Bits per symbol
    localparam int DEF_CHAN_LIMIT  = 0;        // Highest channel
    localparam int DEF_READY_DELAY = 0;        // Ready latency
    localparam bit DEF_MSB_ORDER   = 1'b0;     // Lead symbol in LSBs
    localparam int LAT_MAX         = 8;        // Deepest ready latency
endpackage

//--- sim/stream_sink_model.sv
/*
 * Sink model for the stream source bench: paces its ready line and
 * captures every qualified beat with its side signals.
 * Assumes ready latency zero and the source's own clock and reset.
 */
`timescale 1ns/100ps
module stream_sink_model #(
    parameter int dw = 32  // Payload width
) (
    input  wire logic          core_clk,  // Shared clock
    input  wire logic          reset_n,   // Sync reset, low
    input  wire logic [1:0]    pace,      // 0 ready, 1 alternate, 2 stall
    input  wire logic          src_valid, // Qualifier
    input  wire logic [dw-1:0] src_data,  // Payload
    input  wire logic [17:0]   src_side,  // Channel, error, empty
    input  wire logic          src_sop,   // Start marker
    input  wire logic          src_eop,   // End marker
    output logic               src_ready, // Backpressure release
    output logic [dw-1:0]      got_data,  // Last payload taken
    output logic [17:0]        got_side,  // Last side fields taken
    output logic [1:0]         got_marks, // Last start and end markers
    output int                 got_cnt    // Beats taken since reset
);
    logic tog_ff;  // Alternating phase for slow pacing

    // ------------------------------------------------------------
    // Ready pacing
    // ------------------------------------------------------------
    // Ready asserted on n marks n as the ready cycle at latency zero
    assign src_ready = (pace == 2'h0) | ((pace == 2'h1) & tog_ff);

    // Capture only qualified ready cycles, inputs used unregistered
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            tog_ff  <= 1'b0;
            got_cnt <= 0;
        end else begin
            tog_ff <= ~tog_ff;
            if (src_valid && src_ready) begin
                got_data  <= src_data;
                got_side  <= src_side;
                got_marks <= {src_sop, src_eop};
                got_cnt   <= got_cnt + 1;
            end
        end
    end
endmodule

//--- sim/stream_src_ctrl_test.sv
/*
 * Self-checking bench for the stream source controller: software
 * stages beats through the register port, a sink model paces them.
 * Assumes four 8-bit symbols per beat and a channel limit of 3.
 */
`timescale 1ns/100ps
`define CHK(act, exp) begin compares++; if ((act) !== (exp)) begin mismatches++; \
    $display("unexpected at %0t: got %h exp %h", $time, act, exp); end end
module stream_src_ctrl_test;
    import stream_src_pkg::*;
    logic        core_clk = 1'b0;   // 250 MHz clock
    logic        reset_n  = 1'b0;   // Sync reset, low
    logic [3:0]  addr     = 4'h0;   // Register offset
    logic [31:0] wr_data  = 32'h0;  // Write data
    logic        wr_strobe = 1'b0;  // Write pulse
    logic        rd_strobe = 1'b0;  // Read pulse
    logic [31:0] rd_data;           // Read answer
    logic        src_ready, src_valid, src_sop, src_eop;
    logic [31:0] src_data, got_data;
    logic [7:0]  src_channel, src_error;
    logic [1:0]  src_empty, got_marks, pace = 2'h0;
    logic [17:0] got_side;
    logic [31:0] r;                 // Scratch read value
    int          got_cnt, mismatches = 0, compares = 0;

    always #2 core_clk = ~core_clk;

    stream_src_ctrl #(.beat_symbol_count(4), .channel_number_limit(3)) i_stream_src_ctrl (
        .core_clk(core_clk), .reset_n(reset_n), .addr(addr), .wr_data(wr_data),
        .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .rd_data(rd_data),
        .src_ready(src_ready), .src_valid(src_valid), .src_data(src_data),
        .src_channel(src_channel), .src_error(src_error), .src_sop(src_sop),
        .src_eop(src_eop), .src_empty(src_empty));
    stream_sink_model #(.dw(32)) i_stream_sink_model (
        .core_clk(core_clk), .reset_n(reset_n), .pace(pace), .src_valid(src_valid),
        .src_data(src_data), .src_side({src_channel, src_error, src_empty}),
        .src_sop(src_sop), .src_eop(src_eop), .src_ready(src_ready),
        .got_data(got_data), .got_side(got_side), .got_marks(got_marks), .got_cnt(got_cnt));

    // ------------------------------------------------------------
    // Bus tasks
    // ------------------------------------------------------------
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge core_clk);
        addr      <= a;
        wr_data   <= d;
        wr_strobe <= 1'b1;
        @(posedge core_clk);
        wr_strobe <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge core_clk);
        addr      <= a;
        rd_strobe <= 1'b1;
        @(posedge core_clk);
        rd_strobe <= 1'b0;
        #1 d = rd_data;
    endtask

    // Bounded wait until the sink has taken n beats
    task automatic wait_beat(input int n);
        for (int i = 0; i < 40 && got_cnt != n; i++) begin
            @(posedge core_clk);
            #1;
        end
        `CHK(got_cnt, n)
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        `CHK({src_valid, src_sop, src_eop}, 3'h0)
        rd(ADDR_STATUS, r);
        `CHK(r, 32'h0)
        rd(4'h2, r);  // Unmapped offset reads zero
        `CHK(r, 32'h0)
        $display("test reset done");
    endtask

    // Full-featured single beat, symbol 0 lands in the low bits
    task automatic t_beat();
        wr(ADDR_DATA, 32'h11223344);
        wr(ADDR_CTRL, 32'h81020107);
        wait_beat(1);
        `CHK(got_data, 32'h44332211)
        `CHK(got_marks, 2'h3)
        `CHK(got_side, {8'h02, 8'h81, 2'h1})
        $display("test beat done");
    endtask

    // Beat held while the sink stalls, taken on release
    task automatic t_stall();
        pace <= 2'h2;
        wr(ADDR_DATA, 32'h01020304);
        wr(ADDR_CTRL, 32'h00000007);
        repeat (6) @(posedge core_clk);
        #1;
        `CHK(src_valid, 1'b1)
        `CHK(src_data, 32'h04030201)
        `CHK(got_cnt, 1)
        rd(ADDR_STATUS, r);
        `CHK(r[STAT_VALID], 1'b1)
        pace <= 2'h0;
        wait_beat(2);
        $display("test stall done");
    endtask

    // Over-limit channel refused; empty ignored without end marker
    task automatic t_refuse();
        wr(ADDR_CTRL, 32'h00040007);
        rd(ADDR_STATUS, r);
        `CHK(r, 32'h4)
        @(posedge core_clk);
        #1;
        `CHK(rd_data, 32'h0)
        wr(ADDR_STATUS, 32'h4);
        rd(ADDR_STATUS, r);
        `CHK(r, 32'h0)
        `CHK(got_cnt, 2)
        pace <= 2'h1;
        wr(ADDR_DATA, 32'ha1b2c3d4);
        wr(ADDR_CTRL, 32'h00010303);
        wait_beat(3);
        `CHK(got_data, 32'hd4c3b2a1)
        `CHK(got_marks, 2'h2)
        `CHK(got_side, {8'h01, 8'h00, 2'h0})
        rd(ADDR_COUNT, r);
        `CHK(r, 32'h3)
        $display("test refuse done");
    endtask

    // ------------------------------------------------------------
    // Verdict, watchdog and main sequence
    // ------------------------------------------------------------
    task automatic stop_test();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Tests take well under 1000 cycles
    initial begin
        #20000;
        mismatches++;
        stop_test();
    end

    initial begin
        repeat (8) @(posedge core_clk);
        reset_n <= 1'b1;
        @(posedge core_clk);
        #1;
        t_reset();
        t_beat();
        t_stall();
        t_refuse();
        stop_test();
    end
endmodule
